// [verilog/avd_pkg.sv]
`default_nettype none
package avd_pkg;
    // ---------------------------------------------------------------
    // register indexes (byte address = index * 4)
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W        = 18;
    localparam logic [15:0] IDX_PLAY_MUTE = 16'h0005;
    localparam logic [15:0] IDX_REC_CFG   = 16'h0007;
    localparam logic [15:0] IDX_STATUS    = 16'h0008;
    localparam logic [15:0] IDX_L_VOL     = 16'h0015;
    localparam logic [15:0] IDX_R_VOL     = 16'h0016;
    localparam logic [15:0] IDX_REC_EN    = 16'h0019;
    localparam logic [15:0] IDX_PLAY_EN   = 16'h001a;
    localparam logic [15:0] IDX_DSP_PWR   = 16'h0300;
    localparam logic [15:0] IDX_DSP_RUN   = 16'h040d;
    localparam logic [15:0] IDX_ENH       = 16'h4005;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int unsigned VOL_UPD_BIT    = 8;
    localparam int unsigned CFG_CLK_BIT    = 0;
    localparam int unsigned CFG_RATIO_LSB  = 1;
    localparam int unsigned CFG_RATE_LSB   = 4;
    localparam int unsigned CFG_OSR_BIT    = 6;
    localparam int unsigned CFG_MONO_BIT   = 7;
    localparam int unsigned CFG_WIDE_BIT   = 8;
    localparam int unsigned STAT_RIGHT_LSB = 8;
    localparam int unsigned STAT_RUN_BIT   = 16;
    localparam int unsigned STAT_CLK_BIT   = 17;

    // ---------------------------------------------------------------
    // reset values and gain constants
    // ---------------------------------------------------------------
    localparam logic [7:0]  VOL_RESET   = 8'hc0;
    localparam logic [8:0]  GAIN_UNITY  = 9'h0c0;
    localparam logic [7:0]  GAIN_MUTE   = 8'h00;
    localparam logic [4:0]  MANT_FRAC   = 5'h0e;
    localparam logic [2:0]  RATIO_RESET = 3'h2;
    localparam logic [1:0]  RATE_RESET  = 2'h0;
    localparam logic        OSR_RESET   = 1'b0;
    // 10^(0.375*r/20) in unsigned 2.14
    localparam logic [15:0] GAIN_MANT [16] = '{
        16'h4000, 16'h42d3, 16'h45c6, 16'h48da, 16'h4c11, 16'h4f6c, 16'h52ed, 16'h5695,
        16'h5a67, 16'h5e64, 16'h628e, 16'h66e8, 16'h6b72, 16'h7030, 16'h7523, 16'h7a4e};

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } avd_sample_s;

    typedef struct packed {
        logic vss;
        logic hpb;
        logic hpa;
        logic bass;
        logic play_corr;
        logic rec_corr;
    } avd_enh_s;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } avd_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } avd_apb_rsp_s;
endpackage : avd_pkg
`default_nettype wire

// [verilog/avd_record_gain.sv]
`timescale 1ns/1ps
`default_nettype none
module avd_record_gain (
    input  wire logic [7:0]  code_in,
    input  wire logic [23:0] sample_in,
    output logic      [23:0] sample_out
);
    import avd_pkg::*;

    logic signed [8:0]  steps;
    logic signed [4:0]  octave;
    logic        [4:0]  shift;
    logic signed [40:0] prod;
    logic signed [40:0] scaled;

    // gain = 2^octave * mantissa(step within octave)
    always_comb begin
        steps  = $signed({1'b0, code_in}) - $signed(GAIN_UNITY);
        octave = steps[8:4];
        shift  = MANT_FRAC - octave;
        prod   = $signed(sample_in) * $signed({1'b0, GAIN_MANT[steps[3:0]]});
        scaled = prod >>> shift;
        if (code_in == GAIN_MUTE) begin
            sample_out = 24'h000000;
        end else if (scaled > 41'sh000007fffff) begin
            sample_out = 24'h7fffff;
        end else if (scaled < -41'sh00000800000) begin
            sample_out = 24'h800000;
        end else begin
            sample_out = scaled[23:0];
        end
    end
endmodule : avd_record_gain
`default_nettype wire

// [verilog/avd_adc_clock.sv]
`timescale 1ns/1ps
`default_nettype none
module avd_adc_clock (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       enable_in,
    input  wire logic [2:0] ratio_in,
    input  wire logic [1:0] rate_in,
    input  wire logic       osr_high_in,
    output logic            adc_clk_out
);
    import avd_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       adc_clk;
    } avd_clk_state_s;

    avd_clk_state_s st_reg;
    avd_clk_state_s st_next;
    logic [3:0]     sh;
    logic [7:0]     half;

    // half period 2^(ratio+rate) cycles, halved for high oversampling, capped at 128 cycles
    always_comb begin
        sh = {1'b0, ratio_in} + {2'b00, rate_in};
        if (osr_high_in && sh != 4'h0) begin
            sh = sh - 4'h1;
        end
        if (sh > 4'h7) begin
            sh = 4'h7;
        end
        half    = (8'h01 << sh[2:0]) - 8'h01;
        st_next = st_reg;
        if (!enable_in) begin
            st_next = '0;
        end else if (st_reg.cnt >= half) begin
            st_next.cnt     = 8'h00;
            st_next.adc_clk = !st_reg.adc_clk;
        end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
        if (reset_in) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    assign adc_clk_out = st_reg.adc_clk;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_half_period: assert property (@(posedge clk_in) disable iff (reset_in)
        enable_in && st_reg.cnt >= half ##1 enable_in |-> $changed(st_reg.adc_clk))
        else $error("adc clock did not toggle at half period");
endmodule : avd_adc_clock
`default_nettype wire

// [verilog/avd_record_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - ADC clock runs only with core clock enable
// - clock rate follows sample rate and ratio
// - per-channel gain -71.625 to +23.625 dB
// - gain 0.375dB*(X-192), code zero mutes
// - update bit clear: store, keep gain
// - update bit set: both gains apply together
// - oversampling ratio selectable, resets to low
// - mono mix sums channels, halves sum
// - record and playback correction independently enabled
module avd_record_ctrl (
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire avd_pkg::avd_apb_req_s apb_req_in,
    output avd_pkg::avd_apb_rsp_s      apb_rsp_out,
    input  wire avd_pkg::avd_sample_s  record_sample_in,
    input  wire logic                 record_valid_in,
    output avd_pkg::avd_sample_s       record_sample_out,
    output logic                      record_valid_out,
    output logic                      adc_clk_out,
    output logic [1:0]                record_on_out,
    output logic [1:0]                playback_on_out,
    output logic                      playback_mute_out,
    output logic                      dsp_power_on_out,
    output logic                      record_widening_on_out,
    output avd_pkg::avd_enh_s          enhancement_on_out
);
    import avd_pkg::*;

    typedef struct packed {
        avd_apb_rsp_s rsp;
        logic [7:0]   pend_l;
        logic [7:0]   pend_r;
        logic [7:0]   act_l;
        logic [7:0]   act_r;
        logic         mute;
        logic [1:0]   rec_on;
        logic [1:0]   play_on;
        logic         dsp_pwr;
        logic         dsp_run;
        avd_enh_s     enh;
        avd_enh_s     enh_eff;
        logic         clk_en;
        logic [2:0]   ratio;
        logic [1:0]   rate;
        logic         oversampling_ratio;
        logic         mono;
        logic         wide;
        avd_sample_s  dout;
        logic         dout_valid;
    } avd_ctrl_state_s;

    avd_ctrl_state_s st_reg;
    avd_ctrl_state_s st_next;
    logic            acc;
    logic            hit;
    logic            wr_done;
    logic [15:0]     idx;
    logic [31:0]     rdata;
    logic [31:0]     wd;
    logic [23:0]     gain_l;
    logic [23:0]     gain_r;
    logic [24:0]     mix_sum;

    // ---------------------------------------------------------------
    // clock and gain stages
    // ---------------------------------------------------------------
    avd_adc_clock u_adc_clock (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .enable_in   (st_reg.clk_en),
        .ratio_in    (st_reg.ratio),
        .rate_in     (st_reg.rate),
        .osr_high_in (st_reg.oversampling_ratio),
        .adc_clk_out (adc_clk_out)
    );

    avd_record_gain u_gain_left (
        .code_in    (st_reg.act_l),
        .sample_in  (record_sample_in.left),
        .sample_out (gain_l)
    );

    avd_record_gain u_gain_right (
        .code_in    (st_reg.act_r),
        .sample_in  (record_sample_in.right),
        .sample_out (gain_r)
    );

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    always_comb begin
        acc     = apb_req_in.psel && apb_req_in.penable;
        idx     = apb_req_in.paddr[ADDR_W-1:2];
        wd      = apb_req_in.pwdata;
        hit     = apb_req_in.paddr[1:0] == 2'b00;
        rdata   = 32'h00000000;
        case (idx)
            IDX_PLAY_MUTE: rdata[0] = st_reg.mute;
            IDX_L_VOL:     rdata[7:0] = st_reg.pend_l;
            IDX_R_VOL:     rdata[7:0] = st_reg.pend_r;
            IDX_REC_EN:    rdata[1:0] = st_reg.rec_on;
            IDX_PLAY_EN:   rdata[1:0] = st_reg.play_on;
            IDX_DSP_PWR:   rdata[0] = st_reg.dsp_pwr;
            IDX_DSP_RUN:   rdata = 32'h00000000;
            IDX_ENH:       rdata[5:0] = st_reg.enh;
            IDX_REC_CFG: begin
                rdata[CFG_CLK_BIT]                    = st_reg.clk_en;
                rdata[CFG_RATIO_LSB +: 3]             = st_reg.ratio;
                rdata[CFG_RATE_LSB +: 2]              = st_reg.rate;
                rdata[CFG_OSR_BIT]                    = st_reg.oversampling_ratio;
                rdata[CFG_MONO_BIT]                   = st_reg.mono;
                rdata[CFG_WIDE_BIT]                   = st_reg.wide;
            end
            IDX_STATUS: begin
                rdata[7:0]                  = st_reg.act_l;
                rdata[STAT_RIGHT_LSB +: 8]  = st_reg.act_r;
                rdata[STAT_RUN_BIT]         = st_reg.dsp_run;
                rdata[STAT_CLK_BIT]         = adc_clk_out;
            end
            default: hit = 1'b0;
        endcase
        wr_done = acc && st_reg.rsp.pready && apb_req_in.pwrite && hit;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // one wait state, then answer for one cycle
        if (acc && !st_reg.rsp.pready) begin
            st_next.rsp.pready  = 1'b1;
            st_next.rsp.pslverr = !hit;
            st_next.rsp.prdata  = apb_req_in.pwrite ? 32'h00000000 : rdata;
        end else begin
            st_next.rsp = '0;
        end

        if (wr_done) begin
            case (idx)
                IDX_PLAY_MUTE: st_next.mute = wd[0];
                IDX_L_VOL: begin
                    st_next.pend_l = wd[7:0];
                    if (wd[VOL_UPD_BIT]) begin
                        st_next.act_l = wd[7:0];
                        st_next.act_r = st_reg.pend_r;
                    end
                end
                IDX_R_VOL: begin
                    st_next.pend_r = wd[7:0];
                    if (wd[VOL_UPD_BIT]) begin
                        st_next.act_l = st_reg.pend_l;
                        st_next.act_r = wd[7:0];
                    end
                end
                IDX_REC_EN:  st_next.rec_on = wd[1:0];
                IDX_PLAY_EN: st_next.play_on = wd[1:0];
                IDX_DSP_PWR: begin
                    st_next.dsp_pwr = wd[0];
                    if (!wd[0]) begin
                        st_next.dsp_run = 1'b0;
                    end
                end
                IDX_DSP_RUN: begin
                    if (wd[0] && st_reg.dsp_pwr) begin
                        st_next.dsp_run = 1'b1;
                    end
                end
                IDX_ENH: st_next.enh = wd[5:0];
                IDX_REC_CFG: begin
                    st_next.clk_en = wd[CFG_CLK_BIT];
                    st_next.ratio  = wd[CFG_RATIO_LSB +: 3];
                    st_next.rate   = wd[CFG_RATE_LSB +: 2];
                    st_next.oversampling_ratio    = wd[CFG_OSR_BIT];
                    st_next.mono   = wd[CFG_MONO_BIT];
                    st_next.wide   = wd[CFG_WIDE_BIT];
                end
                default: st_next.mute = st_reg.mute;
            endcase
        end

        // all correction paths gated together on dsp power and dsp run
        st_next.enh_eff = st_reg.enh & {6{st_reg.dsp_pwr && st_reg.dsp_run}};

        // record datapath: gain, enables, mono mix
        st_next.dout_valid = record_valid_in && st_reg.clk_en;
        if (record_valid_in && st_reg.clk_en) begin
            st_next.dout.left  = st_reg.rec_on[0] ? gain_l : 24'h000000;
            st_next.dout.right = st_reg.rec_on[1] ? gain_r : 24'h000000;
            if (st_reg.mono && !st_reg.wide) begin
                st_next.dout.left  = mix_sum[24:1];
                st_next.dout.right = mix_sum[24:1];
            end
        end

        if (reset_in) begin
            st_next        = '0;
            st_next.pend_l = VOL_RESET;
            st_next.pend_r = VOL_RESET;
            st_next.act_l  = VOL_RESET;
            st_next.act_r  = VOL_RESET;
            st_next.ratio  = RATIO_RESET;
            st_next.rate   = RATE_RESET;
            st_next.oversampling_ratio    = OSR_RESET;
        end
    end

    assign mix_sum = {st_reg.rec_on[0] ? gain_l[23] : 1'b0, st_reg.rec_on[0] ? gain_l : 24'h000000}
                   + {st_reg.rec_on[1] ? gain_r[23] : 1'b0, st_reg.rec_on[1] ? gain_r : 24'h000000};

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign apb_rsp_out            = st_reg.rsp;
    assign record_sample_out      = st_reg.dout;
    assign record_valid_out       = st_reg.dout_valid;
    assign record_on_out          = st_reg.rec_on;
    assign playback_on_out        = st_reg.play_on;
    assign playback_mute_out      = st_reg.mute;
    assign dsp_power_on_out       = st_reg.dsp_pwr;
    assign record_widening_on_out = st_reg.wide;
    assign enhancement_on_out     = st_reg.enh_eff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_clock_gated_off: assert property (@(posedge clk_in) disable iff (reset_in)
        !st_reg.clk_en |=> !adc_clk_out && !record_valid_out)
        else $error("adc clock or data ran without core clock enable");

    a_unity_gain_pass: assert property (@(posedge clk_in) disable iff (reset_in)
        record_valid_in && st_reg.clk_en && st_reg.rec_on[0] && !st_reg.mono && st_reg.act_l == 8'hc0
        |=> record_sample_out.left == $past(record_sample_in.left))
        else $error("code 192 did not pass sample unchanged");

    a_mute_code_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        record_valid_in && st_reg.clk_en && !st_reg.mono && st_reg.act_r == 8'h00
        |=> record_sample_out.right == 24'h000000)
        else $error("code zero did not mute");

    a_pending_no_apply: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_done && (idx == IDX_L_VOL || idx == IDX_R_VOL) && !wd[VOL_UPD_BIT]
        |=> $stable(st_reg.act_l) && $stable(st_reg.act_r))
        else $error("active gain changed without update bit");

    a_update_both: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_done && (idx == IDX_L_VOL || idx == IDX_R_VOL) && wd[VOL_UPD_BIT]
        |=> st_reg.act_l == st_reg.pend_l && st_reg.act_r == st_reg.pend_r)
        else $error("update bit did not apply both gains");

    a_active_only_upd: assert property (@(posedge clk_in) disable iff (reset_in)
        $changed(st_reg.act_l) || $changed(st_reg.act_r) |-> $past(wr_done && wd[VOL_UPD_BIT]))
        else $error("active gain moved without update strobe");

    a_osr_reset_low: assert property (@(posedge clk_in) disable iff (reset_in)
        $fell(reset_in) |-> !st_reg.oversampling_ratio ##1 !st_reg.oversampling_ratio)
        else $error("oversampling ratio not low after reset");

    a_mono_equal: assert property (@(posedge clk_in) disable iff (reset_in)
        record_valid_in && st_reg.clk_en && st_reg.mono && !st_reg.wide
        |=> record_sample_out.left == record_sample_out.right)
        else $error("mono mix channels differ");

    a_both_corr_on: assert property (@(posedge clk_in) disable iff (reset_in)
        st_reg.dsp_pwr && st_reg.dsp_run && st_reg.enh.rec_corr && st_reg.enh.play_corr
        |=> enhancement_on_out.rec_corr && enhancement_on_out.play_corr)
        else $error("record and playback correction not both on");

    a_valid_follows: assert property (@(posedge clk_in) disable iff (reset_in)
        record_valid_in && st_reg.clk_en |=> record_valid_out)
        else $error("accepted sample gave no output pulse");

    a_enh_power_gate: assert property (@(posedge clk_in) disable iff (reset_in)
        !st_reg.dsp_pwr |=> enhancement_on_out == '0)
        else $error("enhancement enabled without dsp power");

    c_gain_update:  cover property (@(posedge clk_in) wr_done && wd[VOL_UPD_BIT]);
    c_gain_pending: cover property (@(posedge clk_in) wr_done && idx == IDX_L_VOL && !wd[VOL_UPD_BIT]);
    c_mono_active:  cover property (@(posedge clk_in) record_valid_out && st_reg.mono);
    c_both_corr:    cover property (@(posedge clk_in) enhancement_on_out.rec_corr && enhancement_on_out.play_corr);
endmodule : avd_record_ctrl
`default_nettype wire

// [dv/avd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module avd_host_model (
    input  wire logic                  clk_in,
    output avd_pkg::avd_apb_req_s      req_out,
    input  wire avd_pkg::avd_apb_rsp_s rsp_in
);
    import avd_pkg::*;
    // -------------------------------------------
    // apb master: request held until pready
    // -------------------------------------------
    initial req_out = '0;
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        req_out <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
        @(posedge clk_in);
        req_out.penable <= 1'b1;
        do @(posedge clk_in); while (rsp_in.pready !== 1'b1);
        rd = rsp_in.prdata;
        err = rsp_in.pslverr;
        req_out <= '0;
    endtask : xfer
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, idx, wd, rd, err);
    endtask : wr
    task automatic set_cfg(input logic [31:0] cfg);
        if (cfg[CFG_MONO_BIT]) cfg[CFG_WIDE_BIT] = 1'b0;
        wr(IDX_REC_CFG, cfg);
    endtask : set_cfg
    // -------------------------------------------
    // enhancement enable, all initially off
    // -------------------------------------------
    task automatic enable_seq(input logic [5:0] enh, input logic [7:0] lv, input logic [7:0] rv);
        wr(IDX_L_VOL, 32'h000);
        wr(IDX_R_VOL, 32'h100);
        wr(IDX_REC_EN, 32'h0);
        wr(IDX_PLAY_MUTE, 32'h1);
        wr(IDX_PLAY_EN, 32'h0);
        wr(IDX_DSP_PWR, 32'h1);
        for (int a = 0; a < 2; a++) begin
            wr(16'h4200 + 16'(a), 32'h0);
        end
        wr(IDX_DSP_RUN, 32'h1);
        if ({enh[5], enh[2:0]} == 4'h0) enh[4:3] = 2'b00;
        wr(IDX_ENH, {26'h0, enh});
        wr(IDX_REC_EN, 32'h3);
        wr(IDX_L_VOL, {24'h0, lv});
        wr(IDX_R_VOL, {23'h0, 1'b1, rv});
        wr(IDX_PLAY_EN, 32'h3);
        wr(IDX_PLAY_MUTE, 32'h0);
    endtask : enable_seq
    task automatic rewrite_seq(input logic [5:0] enh, input logic [7:0] lv, input logic [7:0] rv);
        wr(IDX_L_VOL, 32'h000);
        wr(IDX_R_VOL, 32'h100);
        wr(IDX_PLAY_MUTE, 32'h1);
        wr(IDX_ENH, {26'h0, enh});
        wr(IDX_L_VOL, {24'h0, lv});
        wr(IDX_R_VOL, {23'h0, 1'b1, rv});
        wr(IDX_PLAY_MUTE, 32'h0);
    endtask : rewrite_seq
endmodule : avd_host_model
`default_nettype wire

// [dv/tb_avd_record_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_avd_record_ctrl;
    import avd_pkg::*;
    logic               clk_in;
    logic               reset_in;
    logic               valid_in;
    logic               valid_out;
    logic               adc_clk;
    logic               mute;
    logic               pwr;
    logic               wide;
    logic [1:0]         rec_on;
    logic [1:0]         play_on;
    avd_apb_req_s       req;
    avd_apb_rsp_s       rsp;
    avd_sample_s        smp_in;
    avd_sample_s        smp_out;
    avd_enh_s           enh;
    int                 n_errors;
    int                 samples_checked;
    int                 cycles;
    logic [31:0]        rd;
    logic               err;
    logic [7:0]         cl;
    logic [7:0]         cr;
    logic [5:0]         cfg;
    logic signed [23:0] xl;
    logic signed [23:0] xr;
    logic signed [24:0] m;

    avd_record_ctrl DUT (.clk_in(clk_in), .reset_in(reset_in), .apb_req_in(req), .apb_rsp_out(rsp),
        .record_sample_in(smp_in), .record_valid_in(valid_in), .record_sample_out(smp_out),
        .record_valid_out(valid_out), .adc_clk_out(adc_clk), .record_on_out(rec_on),
        .playback_on_out(play_on), .playback_mute_out(mute), .dsp_power_on_out(pwr),
        .record_widening_on_out(wide), .enhancement_on_out(enh));
    avd_host_model host (.clk_in(clk_in), .req_out(req), .rsp_in(rsp));

    // -------------------------------------------
    // checks and helpers
    // -------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_near(input string what, input logic signed [23:0] exp, input logic signed [23:0] got);
        samples_checked++;
        if (got !== exp && got !== exp + 24'sd1 && got !== exp - 24'sd1) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_near
    task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        host.xfer(1'b0, idx, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask : rd_chk
    function automatic logic signed [23:0] gain(input logic [7:0] c, input logic signed [23:0] x);
        int     d;
        int     q;
        longint p;
        d = int'(c) - 192;
        q = (d >= 0) ? d / 16 : -((15 - d) / 16);
        p = (longint'(x) * longint'(GAIN_MANT[d - 16 * q])) >>> (14 - q);
        if (c == 8'h00) p = 0;
        if (p > 8388607) p = 8388607;
        if (p < -8388608) p = -8388608;
        return p[23:0];
    endfunction : gain
    task automatic send(input logic signed [23:0] l, input logic signed [23:0] r);
        @(posedge clk_in);
        valid_in <= 1'b1;
        smp_in <= '{l, r};
        @(posedge clk_in);
        valid_in <= 1'b0;
        #1;
    endtask : send
    task automatic half_period(input int exp);
        logic p;
        int   k;
        for (int j = 0; j < 3; j++) begin
            p = adc_clk;
            k = 0;
            while (adc_clk === p && k < 300) begin
                @(posedge clk_in);
                k++;
            end
        end
        chk("half period", 32'(exp), 32'(k));
    endtask : half_period
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            finish_test();
        end
    end

    // -------------------------------------------
    // scenarios
    // -------------------------------------------
    initial begin
        reset_in = 1'b1;
        valid_in = 1'b0;
        smp_in = '0;
        n_errors = 0;
        samples_checked = 0;
        cycles = 0;
        void'($urandom(23));
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk("config", IDX_REC_CFG, 32'h4);
        rd_chk("left vol", IDX_L_VOL, 32'hc0);
        rd_chk("status", IDX_STATUS, 32'hc0c0);
        host.xfer(1'b0, 16'h0100, 32'h0, rd, err);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test reset done");
        host.wr(IDX_L_VOL, 32'h010);
        host.wr(IDX_R_VOL, 32'h020);
        rd_chk("status held", IDX_STATUS, 32'hc0c0);
        rd_chk("right pending", IDX_R_VOL, 32'h20);
        host.wr(IDX_L_VOL, 32'h111);
        rd_chk("status both", IDX_STATUS, 32'h2011);
        $display("test volume update done");
        host.wr(IDX_REC_EN, 32'h3);
        send(24'sd5, 24'sd5);
        chk("valid clock off", 32'h0, {31'h0, valid_out});
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_in);
            chk("clock off", 32'h0, {31'h0, adc_clk});
        end
        $display("test clock gate done");
        for (int i = 0; i < 16; i++) begin
            cl = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h01 : 8'($urandom);
            cr = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : (i == 2) ? 8'hc0 : 8'($urandom);
            cfg = 6'($urandom);
            host.set_cfg({25'h0, cfg, 1'b1});
            half_period(2 ** (((cfg[2:0] + cfg[4:3] - (cfg[5] && (cfg[2:0] + cfg[4:3]) != 0)) > 7) ? 7 :
                (cfg[2:0] + cfg[4:3] - (cfg[5] && (cfg[2:0] + cfg[4:3]) != 0))));
            host.wr(IDX_L_VOL, {24'h0, cl});
            host.wr(IDX_R_VOL, {23'h0, 1'b1, cr});
            xl = 24'($urandom);
            xr = (i == 1) ? 24'sh7fffff : 24'($urandom);
            send(xl, xr);
            chk("valid", 32'h1, {31'h0, valid_out});
            chk_near("left", gain(cl, xl), smp_out.left);
            chk_near("right", gain(cr, xr), smp_out.right);
        end
        $display("test gain and clock done");
        host.wr(IDX_L_VOL, 32'h0c0);
        host.wr(IDX_R_VOL, 32'h1c0);
        host.set_cfg(32'h81);
        xl = 24'($urandom);
        xr = 24'($urandom);
        m = ($signed({xl[23], xl}) + $signed({xr[23], xr})) >>> 1;
        send(xl, xr);
        chk_near("mono left", m[23:0], smp_out.left);
        chk_near("mono right", m[23:0], smp_out.right);
        host.wr(IDX_REC_CFG, 32'h181);
        send(xl, xr);
        chk_near("widened left", xl, smp_out.left);
        $display("test mono done");
        host.enable_seq(6'h0b, 8'hc0, 8'hc0);
        repeat (2) @(posedge clk_in);
        chk("enhancements", 32'h0b, {26'h0, enh});
        chk("outputs", 32'h6f, {25'h0, wide, pwr, mute, play_on, rec_on});
        host.rewrite_seq(6'h24, 8'hc0, 8'hc0);
        repeat (2) @(posedge clk_in);
        chk("enh rewritten", 32'h24, {26'h0, enh});
        host.wr(IDX_DSP_PWR, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("enh power off", 32'h0, {26'h0, enh});
        $display("test enhancements done");
        finish_test();
    end
endmodule : tb_avd_record_ctrl
`default_nettype wire
